// ==== design/stmbr_pkg.sv ====
// Purpose: Constants for the transmit-end, multiprocessor bit and bit rate block.
// Assumes: 8-bit register port, one 50 MHz clock.
// Notes: Offsets, bit positions, the status-flag, divisor, control and interrupt resets and per-bit tick counts are named here once.
package stmbr_pkg;
  // ==========================================================
  // Register offsets.
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_DIVISOR = 4'h1;
  localparam logic [3:0] OFS_CONTROL = 4'h2;
  localparam logic [3:0] OFS_TXDATA = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
  // ==========================================================
  // Status bit positions.
  localparam int ST_TX_MP = 0;
  localparam int ST_RX_MP = 1;
  localparam int ST_TX_END = 2;
  localparam int ST_TX_EMPTY = 7;
  // ==========================================================
  // Control bit positions.
  localparam int CT_TX_EN = 0;
  localparam int CT_RX_EN = 1;
  localparam int CT_MP_EN = 2;
  localparam int CT_SYNC = 3;
  localparam int CT_CKS_LO = 4;
  localparam int CT_CKS_HI = 5;
  // ==========================================================
  // Interrupt bit positions.
  localparam int IRQ_TX_END = 0;
  localparam int IRQ_RX_MP = 1;
  // ==========================================================
  // Reset values.
  localparam logic [7:0] RST_DIVISOR = 8'hff;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic RST_TX_END = 1'b1;
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_MP = 1'b0;
  // ==========================================================
  // Timing: clock-ticks per bit and example figures.
  localparam logic [5:0] ASYNC_TICKS_PER_BIT = 6'h3f;
  localparam logic [5:0] SYNC_TICKS_PER_BIT = 6'h07;
  localparam int CLK_MHZ = 50;
  localparam int EXAMPLE_OSC_MHZ = 10;
  localparam int EXAMPLE_DIVISOR = 15;
  localparam int EXAMPLE_RATE_BPS = 9600;
  localparam int EXAMPLE_CYCLES_PER_BIT = (EXAMPLE_OSC_MHZ * 1000000) / EXAMPLE_RATE_BPS;
  localparam int EXT_CLOCK_FACTOR = 16;
endpackage

// ==== design/stmbr_rate_gen.sv ====
// Purpose: Prescaler and bit rate divider.
// Assumes: Divisor may change at any time; takes effect at next reload.
// Notes: genTick spans 4^n*(N+1) clocks; bitTick one bit time.
module stmbr_rate_gen (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Settings.
  input wire logic [1:0] prescaleSel,
  input wire logic [7:0] divisor,
  input wire logic syncMode,
  // Ticks.
  output logic genTick,
  output logic bitTick
);
  logic [5:0] preCnt; // Free running prescaler.
  logic [7:0] divCnt; // Divider down counter.
  logic [5:0] bitCnt; // Generator ticks within one bit.
  logic preTick; // One cycle per selected prescaled clock.

  // Maps the select to a prescaler mask.
  function automatic logic [5:0] preMask(input logic [1:0] sel);
    case (sel)
      2'h0: preMask = 6'h00;
      2'h1: preMask = 6'h03;
      2'h2: preMask = 6'h0f;
      default: preMask = 6'h3f;
    endcase
  endfunction

  // Selected clock fires when masked prescaler bits are all ones.
  assign preTick = ((preCnt & preMask(prescaleSel)) == preMask(prescaleSel));

  // Prescaler counts every clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      preCnt <= 6'h00;
    end else begin
      preCnt <= preCnt + 6'h01;
    end
  end

  // Divider reloads from the divisor after N+1 prescaled clocks.
  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt <= 8'h00;
      genTick <= 1'b0;
    end else begin
      genTick <= 1'b0;
      if (preTick) begin
        if (divCnt == 8'h00) begin
          divCnt <= divisor;
          genTick <= 1'b1;
        end else begin
          divCnt <= divCnt - 8'h01;
        end
      end
    end
  end

  // Bit time is 64 generator ticks async, 8 sync.
  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt <= 6'h00;
      bitTick <= 1'b0;
    end else begin
      bitTick <= 1'b0;
      if (genTick) begin
        if (bitCnt >= (syncMode ? stmbr_pkg::SYNC_TICKS_PER_BIT : stmbr_pkg::ASYNC_TICKS_PER_BIT)) begin
          bitCnt <= 6'h00;
          bitTick <= 1'b1;
        end else begin
          bitCnt <= bitCnt + 6'h01;
        end
      end
    end
  end

  // Async bit time spans 64 generator ticks.
  // A tick that closes an async bit must follow the last of its 64 generator ticks.
  AST_ASYNC_BIT: assert property (@(posedge clk) disable iff (rst)
    (bitTick && !$past(syncMode)) |-> ($past(genTick) && $past(bitCnt) == stmbr_pkg::ASYNC_TICKS_PER_BIT))
    else $error("Async bit tick without a full count.");
endmodule

// ==== design/stmbr_top.sv ====
// Purpose: Transmit-end flag, multiprocessor bits and bit rate register.
// Assumes: Framing engine on the same clock gives one-cycle event pulses.
// Notes: Registers read back one cycle after the read strobe.
//
// Local design decisions: the placing of the registers and strobed register access.
module stmbr_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Framing engine events.
  input wire logic txLoad,
  input wire logic txLastBit,
  input wire logic rxMpValid,
  input wire logic rxMpBit,
  // Power mode.
  input wire logic lowPowerEntry,
  // Outputs to the framing engine.
  output logic [7:0] txHoldData,
  output logic txHoldWritten,
  output logic txMpBitOut,
  output logic txEnable,
  output logic rxEnable,
  output logic genTick,
  output logic bitTick,
  // Interrupt.
  output logic irq
);
  // ==========================================================
  // State.
  logic [7:0] bitRateDivisor; // Bit rate divisor.
  logic [7:0] control; // Enables, mode and prescale select.
  logic transmitEndFlag; // Transmission ended.
  logic transmitBufferEmptyFlag; // Holding register free.
  logic emptyReadArmed; // Empty flag was read as one.
  logic receivedMultiprocBit; // Last received multiprocessor bit.
  logic transmitMultiprocBit; // Multiprocessor bit to send.
  logic [1:0] irqStatus; // Sticky event bits.
  logic [1:0] irqMask; // Event enables.
  logic prevEnd; // Delayed end flag for edge detection.

  // ==========================================================
  // Decodes.
  logic wrStatus; // Status write.
  logic wrDivisor; // Divisor write.
  logic wrControl; // Control write.
  logic wrTxData; // Holding register write.
  logic wrIrqStatus; // Interrupt status write.
  logic wrIrqMask; // Interrupt mask write.
  logic emptyClear; // Software clears the empty flag.
  logic rxMpCapture; // Received bit is taken.
  logic endRise; // End flag went high.

  // Decodes a write or read strobe to one offset.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs, input logic s);
    hit = s && (a == ofs);
  endfunction

  assign wrStatus = hit(regAddr, stmbr_pkg::OFS_STATUS, regWr);
  assign wrDivisor = hit(regAddr, stmbr_pkg::OFS_DIVISOR, regWr);
  assign wrControl = hit(regAddr, stmbr_pkg::OFS_CONTROL, regWr);
  assign wrTxData = hit(regAddr, stmbr_pkg::OFS_TXDATA, regWr);
  assign wrIrqStatus = hit(regAddr, stmbr_pkg::OFS_IRQ_STATUS, regWr);
  assign wrIrqMask = hit(regAddr, stmbr_pkg::OFS_IRQ_MASK, regWr);

  // A zero written to the empty flag after it was read as one.
  assign emptyClear = wrStatus && emptyReadArmed && !regWrData[stmbr_pkg::ST_TX_EMPTY];

  // Received bit is taken only in async multiprocessor format with receive on.
  assign rxMpCapture = rxMpValid && control[stmbr_pkg::CT_RX_EN]
    && control[stmbr_pkg::CT_MP_EN] && !control[stmbr_pkg::CT_SYNC];

  assign txEnable = control[stmbr_pkg::CT_TX_EN];
  assign rxEnable = control[stmbr_pkg::CT_RX_EN];
  assign endRise = transmitEndFlag && !prevEnd;

  // ==========================================================
  // Divisor: software may touch it at any time.
  // Reset and low-power entry force it to all ones.
  always_ff @(posedge clk) begin
    if (rst) begin
      bitRateDivisor <= stmbr_pkg::RST_DIVISOR;
    end else if (lowPowerEntry) begin
      bitRateDivisor <= stmbr_pkg::RST_DIVISOR;
    end else if (wrDivisor) begin
      bitRateDivisor <= regWrData;
    end
  end

  // Control register.
  always_ff @(posedge clk) begin
    if (rst) begin
      control <= stmbr_pkg::RST_CONTROL;
    end else if (wrControl) begin
      control <= regWrData;
    end
  end

  // ==========================================================
  // Holding register data and its write pulse.
  always_ff @(posedge clk) begin
    if (rst) begin
      txHoldData <= 8'h00;
      txHoldWritten <= 1'b0;
    end else begin
      txHoldWritten <= wrTxData;
      if (wrTxData) begin
        txHoldData <= regWrData;
      end
    end
  end

  // ==========================================================
  // Empty flag: set wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      transmitBufferEmptyFlag <= stmbr_pkg::RST_TX_EMPTY;
    end else if (!txEnable || txLoad) begin
      transmitBufferEmptyFlag <= 1'b1;
    end else if (emptyClear || wrTxData) begin
      transmitBufferEmptyFlag <= 1'b0;
    end
  end

  // Tracks a read of the status while the empty flag is one.
  always_ff @(posedge clk) begin
    if (rst) begin
      emptyReadArmed <= 1'b0;
    end else if (hit(regAddr, stmbr_pkg::OFS_STATUS, regRd) && transmitBufferEmptyFlag) begin
      emptyReadArmed <= 1'b1;
    end else if (emptyClear || !transmitBufferEmptyFlag) begin
      emptyReadArmed <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit-end flag; a status write reaches it only through the empty-flag clear, which also clears it.
  always_ff @(posedge clk) begin
    if (rst) begin
      transmitEndFlag <= stmbr_pkg::RST_TX_END;
    end else if (!txEnable || (txLastBit && transmitBufferEmptyFlag)) begin
      transmitEndFlag <= 1'b1;
    end else if (emptyClear || wrTxData) begin
      transmitEndFlag <= 1'b0;
    end
  end

  // Delayed copy for the interrupt edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      prevEnd <= stmbr_pkg::RST_TX_END;
    end else begin
      prevEnd <= transmitEndFlag;
    end
  end

  // ==========================================================
  // Received multiprocessor bit; holds when receive is off.
  always_ff @(posedge clk) begin
    if (rst) begin
      receivedMultiprocBit <= stmbr_pkg::RST_MP;
    end else if (rxMpCapture) begin
      receivedMultiprocBit <= rxMpBit;
    end
  end

  // Transmit multiprocessor bit is software writable.
  always_ff @(posedge clk) begin
    if (rst) begin
      transmitMultiprocBit <= stmbr_pkg::RST_MP;
    end else if (wrStatus) begin
      transmitMultiprocBit <= regWrData[stmbr_pkg::ST_TX_MP];
    end
  end

  // Bit sent only in async multiprocessor format with transmit on.
  always_ff @(posedge clk) begin
    if (rst) begin
      txMpBitOut <= 1'b0;
    end else begin
      txMpBitOut <= transmitMultiprocBit && txEnable && control[stmbr_pkg::CT_MP_EN]
        && !control[stmbr_pkg::CT_SYNC];
    end
  end

  // ==========================================================
  // Interrupts: sticky, write one to clear, set wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= stmbr_pkg::RST_IRQ;
    end else begin
      if (endRise) begin
        irqStatus[stmbr_pkg::IRQ_TX_END] <= 1'b1;
      end else if (wrIrqStatus && regWrData[stmbr_pkg::IRQ_TX_END]) begin
        irqStatus[stmbr_pkg::IRQ_TX_END] <= 1'b0;
      end
      if (rxMpCapture) begin
        irqStatus[stmbr_pkg::IRQ_RX_MP] <= 1'b1;
      end else if (wrIrqStatus && regWrData[stmbr_pkg::IRQ_RX_MP]) begin
        irqStatus[stmbr_pkg::IRQ_RX_MP] <= 1'b0;
      end
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask <= stmbr_pkg::RST_IRQ;
    end else if (wrIrqMask) begin
      irqMask <= regWrData[1:0];
    end
  end

  // Level interrupt while any unmasked bit stands.
  assign irq = |(irqStatus & irqMask);

  // ==========================================================
  // Read data one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        stmbr_pkg::OFS_STATUS: regRdData <= {transmitBufferEmptyFlag, 4'h0, transmitEndFlag,
          receivedMultiprocBit, transmitMultiprocBit};
        stmbr_pkg::OFS_DIVISOR: regRdData <= bitRateDivisor;
        stmbr_pkg::OFS_CONTROL: regRdData <= control;
        stmbr_pkg::OFS_TXDATA: regRdData <= txHoldData;
        stmbr_pkg::OFS_IRQ_STATUS: regRdData <= {6'h00, irqStatus};
        stmbr_pkg::OFS_IRQ_MASK: regRdData <= {6'h00, irqMask};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ==========================================================
  // Bit rate generator.
  stmbr_rate_gen u_gen (
    .clk(clk),
    .rst(rst),
    .prescaleSel(control[stmbr_pkg::CT_CKS_HI:stmbr_pkg::CT_CKS_LO]),
    .divisor(bitRateDivisor),
    .syncMode(control[stmbr_pkg::CT_SYNC]),
    .genTick(genTick),
    .bitTick(bitTick)
  );

  // ==========================================================
  // Checks.
  AST_END_RO: assert property (@(posedge clk) disable iff (rst)
    (wrStatus && !emptyClear && txEnable && !(txLastBit && transmitBufferEmptyFlag))
    |=> $stable(transmitEndFlag))
    else $error("End flag changed by a status write.");

  AST_END_CLR: assert property (@(posedge clk) disable iff (rst)
    (wrTxData && txEnable && !txLastBit) |=> !transmitEndFlag)
    else $error("End flag not cleared by data write.");

  AST_END_SET_TE: assert property (@(posedge clk) disable iff (rst)
    !txEnable |=> transmitEndFlag)
    else $error("End flag not set with transmit off.");

  AST_END_SET_LAST: assert property (@(posedge clk) disable iff (rst)
    (txLastBit && transmitBufferEmptyFlag) |=> transmitEndFlag)
    else $error("End flag not set after last bit.");

  AST_END_RESET: assert property (@(posedge clk)
    rst |=> transmitEndFlag)
    else $error("End flag reset value wrong.");

  AST_RXMP_CAP: assert property (@(posedge clk) disable iff (rst)
    rxMpCapture |=> (receivedMultiprocBit == $past(rxMpBit)))
    else $error("Received bit not captured.");

  AST_RXMP_HOLD: assert property (@(posedge clk) disable iff (rst)
    (!rxEnable && !lowPowerEntry) |=> $stable(receivedMultiprocBit))
    else $error("Received bit changed with receive off.");

  AST_TXMP_GATE: assert property (@(posedge clk) disable iff (rst)
    (control[stmbr_pkg::CT_SYNC] || !control[stmbr_pkg::CT_MP_EN] || !txEnable)
    |=> !txMpBitOut)
    else $error("Multiprocessor bit sent while ignored.");

  AST_DIV_WRITE: assert property (@(posedge clk) disable iff (rst)
    (wrDivisor && !lowPowerEntry) ##1 hit(regAddr, stmbr_pkg::OFS_DIVISOR, regRd) && !wrDivisor
    && !lowPowerEntry |=> (regRdData == $past(bitRateDivisor)))
    else $error("Divisor read back wrong.");

  AST_DIV_LOWPWR: assert property (@(posedge clk) disable iff (rst)
    lowPowerEntry |=> (bitRateDivisor == 8'hff))
    else $error("Divisor not forced on low power.");

  AST_RD_ONE: assert property (@(posedge clk) disable iff (rst)
    !regRd |=> (regRdData == 8'h00))
    else $error("Read data outside its cycle.");

  COV_END_SET: cover property (@(posedge clk) disable iff (rst)
    txLastBit && transmitBufferEmptyFlag && txEnable);
  COV_EMPTY_CLR: cover property (@(posedge clk) disable iff (rst) emptyClear);
  COV_RXMP: cover property (@(posedge clk) disable iff (rst) rxMpCapture && rxMpBit);
  COV_IRQ: cover property (@(posedge clk) disable iff (rst) irq);
endmodule

// ==== tb/stmbr_line_model.sv ====
// Purpose: Behavioural framing engine and far station for the transmit-end and multiprocessor block.
// Assumes: One clock; all outputs change just after a rising edge.
// Notes: Load and last-bit delays are fixed so the bench can predict status windows.
module stmbr_line_model #(
  parameter int LOAD_AT = 4,
  parameter int LAST_AT = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // From the block.
  input wire logic txHoldWritten,
  input wire logic txEnable,
  // From the bench.
  input wire logic rxSend,
  input wire logic rxValue,
  // To the block.
  output logic txLoad,
  output logic txLastBit,
  output logic rxMpValid,
  output logic rxMpBit
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycle counter of the character being shifted out.
  int cnt;
  // ==========================================================
  // Transmit side
  // Fixed clock counts pace this far side, not the internal generator; no external 16x clock is offered.
  // A written character is moved out of the holding register, then its last bit leaves later.
  always_ff @(posedge clk) begin
    txLoad <= 1'b0;
    txLastBit <= 1'b0;
    if (rst) begin
      cnt <= 0;
    end else if (txHoldWritten && txEnable) begin
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
      if (cnt == LOAD_AT) begin
        txLoad <= 1'b1;
      end
      if (cnt == LAST_AT) begin
        txLastBit <= 1'b1;
        cnt <= 0;
      end
    end
  end
  // ==========================================================
  // Receive side
  // Outside a valid pulse the bit line toggles so a stale value is never mistaken for data.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxMpValid <= 1'b0;
      rxMpBit <= 1'b0;
    end else begin
      rxMpValid <= rxSend;
      rxMpBit <= rxSend ? rxValue : ~rxMpBit;
    end
  end
endmodule

// ==== tb/test_stmbr_top.sv ====
// Purpose: Self-checking bench for the transmit-end, multiprocessor bit and bit rate block.
// Assumes: Register reads return data one cycle after the strobe.
// Notes: Generator periods are table rows; flag behaviour is hand-written below them.
module test_stmbr_top;
  timeunit 1ns;
  timeprecision 100ps;
  // One generator case: settings beside the expected tick periods.
  typedef struct {
    logic [1:0] cks;
    logic [7:0] div;
    logic sync;
    int genP;
    int bitP;
  } stmbr_row_s;
  // Bench signals.
  logic clk, rst, regWr, regRd, txLoad, txLastBit, rxMpValid, rxMpBit, lowPowerEntry, rxSend, rxValue;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, txHoldData, d;
  logic txHoldWritten, txMpBitOut, txEnable, rxEnable, genTick, bitTick, irq;
  int failures, checks_done, cycles, n;
  // Cases: async at every prescale select, then one synchronous case.
  stmbr_row_s rows [5] = '{'{2'h0, 8'h0f, 1'b0, 16, 1024}, '{2'h1, 8'h03, 1'b0, 16, 1024},
    '{2'h2, 8'h01, 1'b0, 32, 2048}, '{2'h3, 8'h00, 1'b0, 64, 4096}, '{2'h0, 8'h03, 1'b1, 4, 32}};
  // ==========================================================
  // Instances
  stmbr_top dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .txLoad(txLoad), .txLastBit(txLastBit), .rxMpValid(rxMpValid),
    .rxMpBit(rxMpBit), .lowPowerEntry(lowPowerEntry), .txHoldData(txHoldData), .txHoldWritten(txHoldWritten),
    .txMpBitOut(txMpBitOut), .txEnable(txEnable), .rxEnable(rxEnable), .genTick(genTick), .bitTick(bitTick),
    .irq(irq));
  stmbr_line_model line (.clk(clk), .rst(rst), .txHoldWritten(txHoldWritten), .txEnable(txEnable),
    .rxSend(rxSend), .rxValue(rxValue), .txLoad(txLoad), .txLastBit(txLastBit), .rxMpValid(rxMpValid),
    .rxMpBit(rxMpBit));
  // ==========================================================
  // Clock and watchdog
  // The clock toggles every 10 ns, a period of 20 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end
  // ==========================================================
  // Tasks
  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  // Distance in cycles between two ticks, after skipping one partial and one full period.
  task automatic measure(input logic useBit, output int p);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(negedge clk);
        p++;
      end while ((useBit ? bitTick : genTick) !== 1'b1 && p < 9000);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst, regWr, regRd, lowPowerEntry, rxSend, rxValue} = 6'b100000;
    regAddr = 4'h0;
    regWrData = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values: end and empty set, both multiprocessor bits clear, divisor all ones.
    rd(stmbr_pkg::OFS_STATUS);
    check("status", d, 8'h84);
    rd(stmbr_pkg::OFS_DIVISOR);
    check("divisor", d, 8'hff);
    $display("reset test done");
    // Generator rows: readback and both tick periods.
    foreach (rows[i]) begin
      wr(stmbr_pkg::OFS_DIVISOR, rows[i].div);
      wr(stmbr_pkg::OFS_CONTROL, {2'h0, rows[i].cks, rows[i].sync, 3'h0});
      rd(stmbr_pkg::OFS_DIVISOR);
      check("divisor", d, rows[i].div);
      measure(1'b0, n);
      check("gen period", 16'(n), 16'(rows[i].genP));
      measure(1'b1, n);
      check("bit period", 16'(n), 16'(rows[i].bitP));
      $display("rate row %0d done", i);
    end
    // Unmapped offset reads zero and ignores writes.
    wr(4'h9, 8'h33);
    rd(4'h9);
    check("unmapped", d, 8'h00);
    // Transmit a character with the multiprocessor bit set and the end interrupt unmasked.
    wr(stmbr_pkg::OFS_IRQ_MASK, 8'h01);
    wr(stmbr_pkg::OFS_CONTROL, 8'h05);
    wr(stmbr_pkg::OFS_STATUS, 8'h81);
    repeat (2) @(negedge clk);
    check("mp out", txMpBitOut, 1'b1);
    wr(stmbr_pkg::OFS_TXDATA, 8'h5a);
    rd(stmbr_pkg::OFS_STATUS);
    check("status busy", d, 8'h01);
    check("hold data", txHoldData, 8'h5a);
    repeat (30) @(posedge clk);
    rd(stmbr_pkg::OFS_STATUS);
    check("status ended", d, 8'h85);
    check("irq set", irq, 1'b1);
    wr(stmbr_pkg::OFS_IRQ_STATUS, 8'h01);
    @(negedge clk);
    check("irq cleared", irq, 1'b0);
    // Clearing the empty flag after reading it as one also clears the end flag.
    rd(stmbr_pkg::OFS_STATUS);
    wr(stmbr_pkg::OFS_STATUS, 8'h01);
    rd(stmbr_pkg::OFS_STATUS);
    check("status cleared", d, 8'h01);
    // Dropping transmit enable sets the end flag and mutes the multiprocessor bit.
    wr(stmbr_pkg::OFS_CONTROL, 8'h04);
    rd(stmbr_pkg::OFS_STATUS);
    check("status te off", d, 8'h85);
    check("mp out te off", txMpBitOut, 1'b0);
    wr(stmbr_pkg::OFS_CONTROL, 8'h0d);
    repeat (2) @(negedge clk);
    check("mp out sync", txMpBitOut, 1'b0);
    wr(stmbr_pkg::OFS_CONTROL, 8'h01);
    repeat (2) @(negedge clk);
    check("mp out no mp", txMpBitOut, 1'b0);
    // A status write with the end bit low must not touch the end flag.
    wr(stmbr_pkg::OFS_STATUS, 8'h80);
    rd(stmbr_pkg::OFS_STATUS);
    check("status ro", d, 8'h84);
    $display("transmit test done");
    // Receive a multiprocessor bit of one, then keep it across a receive disable.
    wr(stmbr_pkg::OFS_IRQ_STATUS, 8'h03);
    wr(stmbr_pkg::OFS_CONTROL, 8'h06);
    @(posedge clk);
    rxSend <= 1'b1;
    rxValue <= 1'b1;
    @(posedge clk);
    rxSend <= 1'b0;
    rd(stmbr_pkg::OFS_STATUS);
    check("rx mp", d, 8'h86);
    check("enables", {txEnable, rxEnable}, 2'b01);
    check("irq masked", irq, 1'b0);
    rd(stmbr_pkg::OFS_IRQ_STATUS);
    check("irq status", d, 8'h02);
    wr(stmbr_pkg::OFS_CONTROL, 8'h04);
    @(posedge clk);
    rxSend <= 1'b1;
    rxValue <= 1'b0;
    @(posedge clk);
    rxSend <= 1'b0;
    wr(stmbr_pkg::OFS_STATUS, 8'h80);
    rd(stmbr_pkg::OFS_STATUS);
    check("rx mp kept", d, 8'h86);
    $display("receive test done");
    // Low-power entry forces the divisor back to all ones.
    wr(stmbr_pkg::OFS_DIVISOR, 8'h0f);
    @(posedge clk);
    lowPowerEntry <= 1'b1;
    @(posedge clk);
    lowPowerEntry <= 1'b0;
    rd(stmbr_pkg::OFS_DIVISOR);
    check("divisor low power", d, 8'hff);
    $display("low power test done");
    // A second reset in mid-run returns the flags to their reset values.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(stmbr_pkg::OFS_STATUS);
    check("status rerun", d, 8'h84);
    $display("second reset test done");
    conclude();
  end
endmodule
